// file: hdl/qsm_map.svh
// Register offsets, field positions and reset values of the quad serial
// master transfer control. Definitions only; include by bare name.
`ifndef QSM_MAP_SVH
`define QSM_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------
`define QSM_A_CTRL 8'h04
`define QSM_A_EXEC 8'h08
`define QSM_A_STAT 8'h10
`define QSM_A_TXD 8'h14
`define QSM_A_RXD 8'h18

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define QSM_C_LEN_HI 31
`define QSM_C_LEN_LO 16
`define QSM_C_LBITS 10
`define QSM_C_CLOSE 9
`define QSM_C_RXEN 6
`define QSM_C_DMA_HI 5
`define QSM_C_DMA_LO 4
`define QSM_C_SRC_HI 3
`define QSM_C_SRC_LO 2
`define QSM_C_MODE_HI 1
`define QSM_C_MODE_LO 0
`define QSM_C_RST 32'h0000_0200
`define QSM_C_WMASK 32'hFFFF_067F
`define QSM_X_GO 0
`define QSM_X_HALT 1
`define QSM_X_FLUSH 2
`define QSM_S_ACT 16
`define QSM_S_STOP 17

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define QSM_BYTE_BITS 4'h8
`define QSM_HALF_CYC 2

`endif

// file: hdl/qsm_pkg.sv
// Types shared by the quad serial master transfer control files.
// Holds no logic; every user names it with the package scope.
package qsm_pkg;
	typedef enum logic [1:0] {
		QSM_LANE_1 = 2'h0,
		QSM_LANE_2 = 2'h1,
		QSM_LANE_4 = 2'h2,
		QSM_LANE_RSVD = 2'h3
	} qsm_lane_t;
	typedef enum logic [1:0] {
		QSM_SRC_OFF = 2'h0,
		QSM_SRC_FIFO = 2'h1,
		QSM_SRC_ZERO = 2'h2,
		QSM_SRC_ONE = 2'h3
	} qsm_src_t;
	typedef enum logic [1:0] {
		QSM_Q_IDLE = 2'h0,
		QSM_Q_LOAD = 2'h1,
		QSM_Q_WAIT = 2'h3
	} qsm_seq_t;
	typedef enum logic [1:0] {
		QSM_L_IDLE = 2'h0,
		QSM_L_LO = 2'h1,
		QSM_L_HI = 2'h3
	} qsm_bit_t;
endpackage

// file: hdl/qsm_link_shifter.sv
// Bit shifter of the quad serial master, clocked by the link clock.
// Assumes the byte, bit count and lane setup stay stable from a request
// toggle until the matching acknowledge toggle.
`timescale 1ns/1ps
`default_nettype none
`include "qsm_map.svh"

module qsm_link_shifter (
	input wire logic link_clk,
	input wire logic rst,
	input wire logic req_tog,
	input wire logic [7:0] tx_byte,
	input wire logic [3:0] nbits,
	input wire qsm_pkg::qsm_lane_t lane,
	input wire qsm_pkg::qsm_src_t src,
	input wire logic cs_req,
	input wire logic [3:0] io_in,
	output logic ack_tog,
	output logic [7:0] rx_byte,
	output logic spi_clk,
	output logic cs_n,
	output logic [3:0] io_out,
	output logic [3:0] io_oe
);
	logic req_s1_q, req_s2_q, req_s3_q, cs_s1_q, cs_s2_q;
	logic [3:0] in_s1_q, in_s2_q, step, mask, out_bits, left_q;
	logic [7:0] tx_sh_q, rx_sh_q, tx_next, rx_next;
	logic ph_q;
	qsm_pkg::qsm_bit_t st_q;

	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	// Pins and the system-domain request and select levels pass two flops before any use.
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			{req_s1_q, req_s2_q, req_s3_q, cs_s1_q, cs_s2_q} <= 5'h00;
			in_s1_q <= 4'h0;
			in_s2_q <= 4'h0;
		end else begin
			{req_s1_q, req_s2_q, req_s3_q} <= {req_tog, req_s1_q, req_s2_q};
			{cs_s1_q, cs_s2_q} <= {cs_req, cs_s1_q};
			in_s1_q <= io_in;
			in_s2_q <= in_s1_q;
		end
	end

	// ------------------------------------------------------------------
	// Lane steering
	// ------------------------------------------------------------------
	// Reserved lane width falls back to single so the pins stay sane.
	always_comb begin
		case (lane)
		qsm_pkg::QSM_LANE_4: begin // R9
			step = 4'h4;
			mask = 4'hF;
			out_bits = tx_sh_q[7:4];
			tx_next = {tx_sh_q[3:0], 4'h0};
			rx_next = {rx_sh_q[3:0], in_s2_q};
		end
		qsm_pkg::QSM_LANE_2: begin // R9
			step = 4'h2;
			mask = 4'h3;
			out_bits = {2'h0, tx_sh_q[7:6]};
			tx_next = {tx_sh_q[5:0], 2'h0};
			rx_next = {rx_sh_q[5:0], in_s2_q[1:0]};
		end
		default: begin
			step = 4'h1;
			mask = 4'h1;
			out_bits = {3'h0, tx_sh_q[7]};
			tx_next = {tx_sh_q[6:0], 1'b0};
			rx_next = {rx_sh_q[6:0], in_s2_q[1]};
		end
		endcase
	end

	// Pin drivers; a disabled transmitter leaves every lane undriven.
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			io_out <= 4'h0;
			io_oe <= 4'h0;
			cs_n <= 1'b1;
		end else begin
			io_out <= out_bits;
			io_oe <= (cs_s2_q && src != qsm_pkg::QSM_SRC_OFF) ? mask : 4'h0; // R8
			cs_n <= ~cs_s2_q;
		end
	end

	// ------------------------------------------------------------------
	// Bit sequencer
	// ------------------------------------------------------------------
	// Each clock half lasts two link cycles so that the input, seen two
	// flops late, is sampled as it stood at the rising edge.
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			st_q <= qsm_pkg::QSM_L_IDLE;
			ph_q <= 1'b0;
			spi_clk <= 1'b0;
			tx_sh_q <= 8'h00;
			rx_sh_q <= 8'h00;
			left_q <= 4'h0;
			ack_tog <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			case (st_q)
			qsm_pkg::QSM_L_IDLE: begin
				spi_clk <= 1'b0;
				if (req_s2_q ^ req_s3_q) begin
					tx_sh_q <= tx_byte;
					rx_sh_q <= 8'h00;
					left_q <= nbits;
					ph_q <= 1'b0;
					st_q <= qsm_pkg::QSM_L_LO;
				end
			end
			qsm_pkg::QSM_L_LO: begin
				ph_q <= ~ph_q;
				if (ph_q) begin
					spi_clk <= 1'b1;
					st_q <= qsm_pkg::QSM_L_HI;
				end
			end
			qsm_pkg::QSM_L_HI: begin
				ph_q <= ~ph_q;
				if (ph_q) begin
					spi_clk <= 1'b0;
					tx_sh_q <= tx_next;
					rx_sh_q <= rx_next;
					if (left_q <= step) begin
						left_q <= 4'h0;
						rx_byte <= rx_next;
						ack_tog <= ~ack_tog;
						st_q <= qsm_pkg::QSM_L_IDLE;
					end else begin
						left_q <= left_q - step;
						st_q <= qsm_pkg::QSM_L_LO;
					end
				end
			end
			default: st_q <= qsm_pkg::QSM_L_IDLE;
			endcase
		end
	end

	AST_TX_OFF_UNDRIVEN: assert property (@(posedge link_clk) disable iff (rst) // R8
		(src == qsm_pkg::QSM_SRC_OFF) |=> (io_oe == 4'h0))
		else $error("Lanes driven while transmit is off.");
	AST_QUAD_LANES: assert property (@(posedge link_clk) disable iff (rst) // R9
		(cs_s2_q && src != qsm_pkg::QSM_SRC_OFF &&
		lane == qsm_pkg::QSM_LANE_4) |=> (io_oe == 4'hF))
		else $error("Quad transfer does not drive all four lanes.");
endmodule
`default_nettype wire

// file: hdl/qsm_transfer_ctrl.sv
// Transfer control of the quad serial master: registers, transmit and
// receive byte queues, DMA refill request and byte sequencer.
// Assumes a register master and DMA on CLK_SYS and a free LINK_CLK.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "qsm_map.svh"

// Functional notes
// R1: DMA size field: off, one, two, four bytes.
// R2: Request DMA refill until length reached or terminated.
// R3: DMA channel access size matches size field.
// R4: Without DMA, firmware fills the transmit queue.
// R5: Source three sends all ones, queue untouched.
// R6: Source two sends all zeros, queue untouched.
// R7: Source one shifts transmit queue data out.
// R8: Source zero leaves data lanes undriven.
// R9: Lane width: single, dual, quad; three reserved.
// R10: Dual or quad needs one direction disabled.
// R11: Flush bit empties both queues, self-clearing.
// R12: Flush discards data and zeroes all counts; code zeroes only the queue counts, not done_q or fed_q.
// R13: Halt ends transfer after current byte, self-clearing.
// R14: Go launches a transfer with current settings.
// R15: Never write go and halt together.
// R16: Length in bytes or bits; zero is endless.
// R17: Receive enable captures incoming bytes into queue.
// R18: Close-on-end drops select, idles, ends DMA.
// R19: Change setup fields only while idle.
module qsm_transfer_ctrl #(
	parameter int TX_DEPTH = 8,
	parameter int RX_DEPTH = 8
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic LINK_CLK,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic [31:0] DMA_WDATA,
	input wire logic DMA_WR,
	input wire logic DMA_TERM,
	output logic TX_DMA_REQ,
	output logic TRANSFER_ACTIVE,
	output logic SPI_CLK,
	output logic SPI_CS_N,
	input wire logic [3:0] SPI_IO_IN,
	output logic [3:0] SPI_IO_OUT,
	output logic [3:0] SPI_IO_OE
);
	localparam int TPW = $clog2(TX_DEPTH);
	localparam int RPW = $clog2(RX_DEPTH);

	logic [31:0] ctrl_q;
	logic [15:0] len, done_q;
	logic [16:0] len_bytes, fed_q;
	logic [1:0] dma_size;
	logic wr_ctrl, wr_exec, wr_tx, rd_rx, go, halt, flush;
	logic stop_q, cs_q, req_tog_q, term_q, cfg_rx_q;
	logic ack_s1_q, ack_s2_q, ack_s3_q, ack_ev, ack_tog;
	logic [7:0] byte_q, launch_byte, rx_byte;
	logic [3:0] nbits_q, step_bits;
	qsm_pkg::qsm_seq_t st_q;
	qsm_pkg::qsm_src_t cfg_src_q;
	qsm_pkg::qsm_lane_t cfg_lane_q;
	logic reached, end_now, launch, tx_pop, rx_push;
	logic [7:0] tx_mem [TX_DEPTH];
	logic [7:0] rx_mem [RX_DEPTH];
	logic [TPW-1:0] tx_wp_q, tx_rp_q;
	logic [RPW-1:0] rx_wp_q, rx_rp_q;
	logic [TPW:0] tx_cnt_q, tx_room;
	logic [RPW:0] rx_cnt_q;
	logic [2:0] push_n, size_n;
	logic [31:0] push_bytes;
	logic tx_empty, rx_full, rx_pop;

	// ------------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------------
	// Execute strobes act in the write cycle and are never stored.
	assign wr_ctrl = WR && ADDR == `QSM_A_CTRL;
	assign wr_exec = WR && ADDR == `QSM_A_EXEC;
	assign wr_tx = WR && ADDR == `QSM_A_TXD;
	assign rd_rx = RD && ADDR == `QSM_A_RXD;
	assign go = wr_exec && WDATA[`QSM_X_GO]; // R14
	assign halt = wr_exec && WDATA[`QSM_X_HALT]; // R13
	assign flush = wr_exec && WDATA[`QSM_X_FLUSH]; // R11

	// Control register; reserved and out-of-scope bits read as zero.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ctrl_q <= `QSM_C_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= WDATA & `QSM_C_WMASK;
		end
	end

	assign len = ctrl_q[`QSM_C_LEN_HI:`QSM_C_LEN_LO];
	assign dma_size = ctrl_q[`QSM_C_DMA_HI:`QSM_C_DMA_LO];
	assign len_bytes = ctrl_q[`QSM_C_LBITS] ?
		(({1'b0, len} + 17'h0_0007) >> 3) : {1'b0, len};

	// Read data stand one cycle after the strobe; a receive read pops.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			RDATA <= 32'h0000_0000;
		end else if (RD) begin
			case (ADDR)
			`QSM_A_CTRL: RDATA <= ctrl_q;
			`QSM_A_STAT: RDATA <= {14'h0000, stop_q, TRANSFER_ACTIVE,
				8'(rx_cnt_q), 8'(tx_cnt_q)};
			`QSM_A_RXD: RDATA <= {24'h00_0000, rx_pop ? rx_mem[rx_rp_q] : 8'h00};
			default: RDATA <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Transmit queue
	// ------------------------------------------------------------------
	// A DMA access pushes its whole width; it wins over a firmware byte
	// in the same cycle, which software avoids by not mixing the two.
	always_comb begin
		tx_room = (TPW+1)'(TX_DEPTH) - tx_cnt_q;
		case (dma_size) // R1
		2'h1: size_n = 3'h1;
		2'h2: size_n = 3'h2;
		2'h3: size_n = 3'h4;
		default: size_n = 3'h0;
		endcase
		push_bytes = DMA_WDATA;
		push_n = 3'h0;
		if (DMA_WR && dma_size != 2'h0) begin
			push_n = size_n;
		end else if (wr_tx) begin
			push_bytes = {24'h00_0000, WDATA[7:0]};
			push_n = 3'h1;
		end
		if (flush) begin
			push_n = 3'h0;
		end else if ((TPW+1)'(push_n) > tx_room) begin
			push_n = 3'(tx_room);
		end
	end

	assign tx_empty = tx_cnt_q == '0;

	always_ff @(posedge CLK_SYS) begin
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < push_n) begin
				tx_mem[TPW'(tx_wp_q + TPW'(i))] <= push_bytes[i*8 +: 8];
			end
		end
	end

	// Flush beats any push or pop in the same cycle.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			tx_wp_q <= '0;
			tx_rp_q <= '0;
			tx_cnt_q <= '0;
		end else if (flush) begin
			tx_wp_q <= '0; // R12
			tx_rp_q <= '0;
			tx_cnt_q <= '0;
		end else begin
			tx_wp_q <= tx_wp_q + TPW'(push_n);
			tx_rp_q <= tx_rp_q + TPW'(tx_pop);
			tx_cnt_q <= tx_cnt_q + (TPW+1)'(push_n) - (TPW+1)'(tx_pop);
		end
	end

	// ------------------------------------------------------------------
	// Receive queue
	// ------------------------------------------------------------------
	assign rx_full = rx_cnt_q == (RPW+1)'(RX_DEPTH);
	assign rx_pop = rd_rx && rx_cnt_q != '0;
	assign rx_push = ack_ev && st_q == qsm_pkg::QSM_Q_WAIT && cfg_rx_q; // R17

	always_ff @(posedge CLK_SYS) begin
		if (rx_push) begin
			rx_mem[rx_wp_q] <= rx_byte;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			rx_wp_q <= '0;
			rx_rp_q <= '0;
			rx_cnt_q <= '0;
		end else if (flush) begin
			rx_wp_q <= '0; // R12
			rx_rp_q <= '0;
			rx_cnt_q <= '0;
		end else begin
			rx_wp_q <= rx_wp_q + RPW'(rx_push);
			rx_rp_q <= rx_rp_q + RPW'(rx_pop);
			rx_cnt_q <= rx_cnt_q + (RPW+1)'(rx_push) - (RPW+1)'(rx_pop);
		end
	end

	// ------------------------------------------------------------------
	// Byte sequencer
	// ------------------------------------------------------------------
	// The acknowledge toggle crosses in two flops; the third only keeps
	// the previous value for the edge.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			{ack_s1_q, ack_s2_q, ack_s3_q} <= 3'h0;
		end else begin
			{ack_s1_q, ack_s2_q, ack_s3_q} <= {ack_tog, ack_s1_q, ack_s2_q};
		end
	end
	assign ack_ev = ack_s2_q ^ ack_s3_q;

	// A zero length never counts as reached, so the transfer runs on.
	assign reached = len != 16'h0000 && done_q >= len; // R16
	assign end_now = st_q == qsm_pkg::QSM_Q_LOAD && (stop_q || halt || reached);
	assign launch = st_q == qsm_pkg::QSM_Q_LOAD && !end_now &&
		!(cfg_rx_q && rx_full) &&
		!(cfg_src_q == qsm_pkg::QSM_SRC_FIFO && tx_empty);
	assign tx_pop = launch && cfg_src_q == qsm_pkg::QSM_SRC_FIFO && !flush;
	assign step_bits = (ctrl_q[`QSM_C_LBITS] && len != 16'h0000 &&
		len - done_q < 16'h0008) ? 4'(len - done_q) : `QSM_BYTE_BITS;

	always_comb begin
		case (cfg_src_q)
		qsm_pkg::QSM_SRC_ONE: launch_byte = 8'hFF; // R5
		qsm_pkg::QSM_SRC_ZERO: launch_byte = 8'h00; // R6
		qsm_pkg::QSM_SRC_FIFO: launch_byte = tx_mem[tx_rp_q]; // R7
		default: launch_byte = 8'h00;
		endcase
	end

	// Go is only heard while idle; halt during a byte waits for its end.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st_q <= qsm_pkg::QSM_Q_IDLE;
			TRANSFER_ACTIVE <= 1'b0;
			stop_q <= 1'b0;
			cs_q <= 1'b0;
			req_tog_q <= 1'b0;
			byte_q <= 8'h00;
			nbits_q <= `QSM_BYTE_BITS;
			done_q <= 16'h0000;
			cfg_src_q <= qsm_pkg::QSM_SRC_OFF;
			cfg_lane_q <= qsm_pkg::QSM_LANE_1;
			cfg_rx_q <= 1'b0;
		end else begin
			case (st_q)
			qsm_pkg::QSM_Q_IDLE: begin
				if (go) begin // R14
					st_q <= qsm_pkg::QSM_Q_LOAD;
					TRANSFER_ACTIVE <= 1'b1;
					cs_q <= 1'b1;
					stop_q <= 1'b0;
					done_q <= 16'h0000;
					cfg_src_q <= qsm_pkg::qsm_src_t'(
						ctrl_q[`QSM_C_SRC_HI:`QSM_C_SRC_LO]);
					cfg_lane_q <= qsm_pkg::qsm_lane_t'(
						ctrl_q[`QSM_C_MODE_HI:`QSM_C_MODE_LO]);
					cfg_rx_q <= ctrl_q[`QSM_C_RXEN];
				end else if (halt) begin
					cs_q <= 1'b0;
				end
			end
			qsm_pkg::QSM_Q_LOAD: begin
				if (end_now) begin
					st_q <= qsm_pkg::QSM_Q_IDLE;
					TRANSFER_ACTIVE <= 1'b0;
					stop_q <= 1'b0;
					if (ctrl_q[`QSM_C_CLOSE] || stop_q || halt) begin
						cs_q <= 1'b0; // R18
					end
				end else if (launch) begin
					byte_q <= launch_byte;
					nbits_q <= step_bits;
					req_tog_q <= ~req_tog_q;
					st_q <= qsm_pkg::QSM_Q_WAIT;
				end
			end
			qsm_pkg::QSM_Q_WAIT: begin
				if (halt) begin
					stop_q <= 1'b1; // R13
				end
				if (ack_ev) begin
					done_q <= done_q + (ctrl_q[`QSM_C_LBITS] ?
						16'(nbits_q) : 16'h0001);
					st_q <= qsm_pkg::QSM_Q_LOAD;
				end
			end
			default: st_q <= qsm_pkg::QSM_Q_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// DMA refill request
	// ------------------------------------------------------------------
	// The request drops in the cycle after an access so the queue count
	// is fresh before it can rise again.
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			TX_DMA_REQ <= 1'b0;
			term_q <= 1'b0;
			fed_q <= 17'h0_0000;
		end else begin
			term_q <= DMA_TERM || (term_q && !go);
			if (go && st_q == qsm_pkg::QSM_Q_IDLE) begin
				fed_q <= 17'h0_0000;
			end else if (DMA_WR && dma_size != 2'h0) begin
				fed_q <= fed_q + 17'(push_n);
			end
			TX_DMA_REQ <= TRANSFER_ACTIVE && dma_size != 2'h0 && // R2
				!term_q && !DMA_TERM && !DMA_WR && !end_now &&
				(len == 16'h0000 || fed_q < len_bytes) &&
				tx_room >= (TPW+1)'(size_n);
		end
	end

	// ------------------------------------------------------------------
	// Link side
	// ------------------------------------------------------------------
	qsm_link_shifter u_link (
		.link_clk(LINK_CLK),
		.rst(RST),
		.req_tog(req_tog_q),
		.tx_byte(byte_q),
		.nbits(nbits_q),
		.lane(cfg_lane_q),
		.src(cfg_src_q),
		.cs_req(cs_q),
		.io_in(SPI_IO_IN),
		.ack_tog(ack_tog),
		.rx_byte(rx_byte),
		.spi_clk(SPI_CLK),
		.cs_n(SPI_CS_N),
		.io_out(SPI_IO_OUT),
		.io_oe(SPI_IO_OE)
	);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	AST_FLUSH_CLEARS: assert property (@(posedge CLK_SYS) disable iff (RST) // R12
		flush |=> (tx_cnt_q == '0 && rx_cnt_q == '0))
		else $error("Flush left data in a queue.");
	AST_GO_STARTS: assert property (@(posedge CLK_SYS) disable iff (RST) // R14
		(go && !TRANSFER_ACTIVE) |=> TRANSFER_ACTIVE && cs_q)
		else $error("Go did not start a transfer.");
	AST_HALT_STOPS: assert property (@(posedge CLK_SYS) disable iff (RST) // R13
		(halt && TRANSFER_ACTIVE) |-> ##[1:200] !TRANSFER_ACTIVE)
		else $error("Halt did not end the transfer in time.");
	AST_DMA_OFF: assert property (@(posedge CLK_SYS) disable iff (RST) // R1
		(dma_size == 2'h0) |=> !TX_DMA_REQ)
		else $error("DMA requested while DMA is off.");
	AST_DMA_TERM: assert property (@(posedge CLK_SYS) disable iff (RST) // R2
		DMA_TERM |=> !TX_DMA_REQ [*2])
		else $error("DMA request after termination.");
	AST_ONES_BYTE: assert property (@(posedge CLK_SYS) disable iff (RST) // R5
		(launch && cfg_src_q == qsm_pkg::QSM_SRC_ONE) |=>
		(byte_q == 8'hFF && $stable(tx_rp_q)))
		else $error("Ones source sent other data.");
	AST_ZERO_BYTE: assert property (@(posedge CLK_SYS) disable iff (RST) // R6
		(launch && cfg_src_q == qsm_pkg::QSM_SRC_ZERO) |=>
		(byte_q == 8'h00 && $stable(tx_rp_q)))
		else $error("Zeros source sent other data.");
	AST_RX_OFF: assert property (@(posedge CLK_SYS) disable iff (RST) // R17
		(!cfg_rx_q && !flush) |=> rx_cnt_q <= $past(rx_cnt_q))
		else $error("Byte captured with receive disabled.");
	AST_CLOSE_END: assert property (@(posedge CLK_SYS) disable iff (RST) // R18
		(end_now && reached && ctrl_q[`QSM_C_CLOSE]) |=>
		(!cs_q && !TRANSFER_ACTIVE) ##1 !TX_DMA_REQ)
		else $error("Close on end left the transfer open.");
endmodule
`default_nettype wire

// file: tb/qsm_slave_model.sv
// Behavioural serial slave for the quad serial master bench.
// Assumes mode 0 framing: data change while the clock is low.
`timescale 1ns/1ps
`default_nettype none

module qsm_slave_model (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] io_out,
	output logic [3:0] io_in,
	output logic [31:0] seen,
	output logic [7:0] nbits
);
	localparam logic [7:0] PAT = 8'hA5;
	logic [2:0] rfl;
	logic [3:0] drv;
	logic [3:0] last = 4'h0;

	// -------------------------------------------------------------
	// Capture and reply
	// -------------------------------------------------------------
	// Lane 0 is captured per rising clock; a new frame starts clean.
	always @(posedge sclk or negedge cs_n) begin
		if (!sclk) begin
			seen <= 32'h0000_0000;
			nbits <= 8'h00;
		end else if (!cs_n) begin
			seen <= {seen[30:0], io_out[0]};
			nbits <= nbits + 8'h01;
		end
	end
	// The reply bit moves on at each falling clock, never at sampling.
	always @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			rfl <= 3'h0;
		end else begin
			rfl <= rfl + 3'h1;
		end
	end
	// Spare lanes toggle so a stale value is never mistaken for data.
	assign drv = {rfl[0], ~rfl[0], PAT[~rfl], rfl[1]};
	always @(posedge sclk) begin
		if (!cs_n) begin
			last <= drv;
		end
	end
	// Not selected: the lines show the inverse of the last value.
	assign io_in = cs_n ? ~last : drv;
endmodule

`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the quad serial master transfer control.
// Assumes the design files and the slave model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "qsm_map.svh"

module tb;
	logic CLK_SYS = 1'b0;
	logic RST = 1'b1;
	logic LINK_CLK = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0000_0000;
	logic [31:0] DMA_WDATA = 32'h0000_0000;
	logic WR = 1'b0, RD = 1'b0, DMA_WR = 1'b0, DMA_TERM = 1'b0;
	logic TX_DMA_REQ, TRANSFER_ACTIVE, SPI_CLK, SPI_CS_N;
	logic [31:0] RDATA, seen, ed, ov, d;
	logic [3:0] SPI_IO_IN, SPI_IO_OUT, SPI_IO_OE, oe_or;
	logic [7:0] nb, b;
	logic [31:0] xs = 32'h0000_0017;
	logic rd_q = 1'b0, dma_on = 1'b0;
	int fails = 0, num_checks = 0, nacc = 0, nby = 1;
	logic [31:0] rq[$], oq[$];
	event oev;
	logic [1:0] tm[5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
	logic [1:0] ts[5] = '{2'h0, 2'h3, 2'h2, 2'h2, 2'h2};
	logic [3:0] to[5] = '{4'h0, 4'h1, 4'h3, 4'hF, 4'h1};

	// System clock; the link clock is offset so phases never line up.
	always #25 CLK_SYS = ~CLK_SYS;
	initial begin
		#7;
		forever #15 LINK_CLK = ~LINK_CLK;
	end

	qsm_transfer_ctrl uut (.CLK_SYS(CLK_SYS), .RST(RST),
		.LINK_CLK(LINK_CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .DMA_WDATA(DMA_WDATA), .DMA_WR(DMA_WR),
		.DMA_TERM(DMA_TERM), .TX_DMA_REQ(TX_DMA_REQ),
		.TRANSFER_ACTIVE(TRANSFER_ACTIVE), .SPI_CLK(SPI_CLK),
		.SPI_CS_N(SPI_CS_N), .SPI_IO_IN(SPI_IO_IN),
		.SPI_IO_OUT(SPI_IO_OUT), .SPI_IO_OE(SPI_IO_OE));
	qsm_slave_model sl (.sclk(SPI_CLK), .cs_n(SPI_CS_N),
		.io_out(SPI_IO_OUT), .io_in(SPI_IO_IN), .seen(seen), .nbits(nb));

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	function automatic logic [31:0] rnd();
		xs = xs ^ (xs << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
		return xs;
	endfunction
	function automatic logic [31:0] cfg(input logic [15:0] l,
		input logic rx, input logic [1:0] dm, input logic [1:0] s,
		input logic [1:0] m);
		return {l, 6'h00, 1'b1, 2'h0, rx, dm, s, m};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLK_SYS);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge CLK_SYS);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge CLK_SYS);
		ADDR <= a;
		RD <= 1'b1;
		rq.push_back(e);
		@(posedge CLK_SYS);
		RD <= 1'b0;
	endtask
	// A short delay keeps two notes in one step from merging.
	task automatic ob(input logic [31:0] v, input logic [31:0] e);
		oq.push_back(e);
		ov = v;
		->oev;
		#1;
	endtask
	task automatic start(input logic [31:0] c, input logic p);
		wr(`QSM_A_EXEC, 32'h0000_0004);
		if (p) wr(`QSM_A_TXD, {24'h00_0000, b});
		wr(`QSM_A_CTRL, c);
		oe_or = 4'h0;
		wr(`QSM_A_EXEC, 32'h0000_0001);
		@(posedge CLK_SYS);
	endtask
	// A hang is left to the watchdog; the extra cycles let the select
	// settle back through the link-side synchroniser before any check.
	task automatic wait_idle();
		while (TRANSFER_ACTIVE !== 1'b0) begin
			@(posedge CLK_SYS);
		end
		repeat (3) @(posedge CLK_SYS);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// -------------------------------------------------------------
	// Monitors and responders
	// -------------------------------------------------------------
	// Read data is defined only in the cycle after the strobe.
	always @(posedge CLK_SYS) begin
		if (rd_q) chk(RDATA, rq.pop_front());
		rd_q <= RD;
		if (SPI_CS_N === 1'b0) oe_or <= oe_or | SPI_IO_OE;
	end
	always @(oev) chk(ov, oq.pop_front());
	// DMA answers one access per request, stalling at random.
	always @(posedge CLK_SYS) begin
		if (dma_on && TX_DMA_REQ === 1'b1 && !DMA_WR && rnd() % 2) begin
			d = rnd();
			DMA_WDATA <= d;
			DMA_WR <= 1'b1;
			nacc++;
			for (int i = 0; i < nby; i++) ed = {ed[23:0], d[8*i+:8]};
		end else begin
			DMA_WR <= 1'b0;
		end
	end
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		fails++;
		summarize();
	end

	// -------------------------------------------------------------
	// Tests
	// -------------------------------------------------------------
	initial begin
		repeat (2) @(posedge CLK_SYS);
		RST <= 1'b0;
		rd(`QSM_A_CTRL, 32'h0000_0200);
		rd(`QSM_A_EXEC, 32'h0000_0000);
		rd(8'h3C, 32'h0000_0000);
		wr(`QSM_A_CTRL, 32'hFFFF_FFFF);
		rd(`QSM_A_CTRL, 32'hFFFF_067F);
		$display("registers done");
		for (int s = 1; s < 4; s++) begin
			b = 8'(rnd());
			start(cfg(16'h0001, 1'b1, 2'h0, s[1:0], 2'h0), 1'b1);
			wait_idle();
			ob(seen[7:0], s == 1 ? b : (s == 2 ? 8'h00 : 8'hFF));
			ob(SPI_CS_N, 32'h0000_0001);
			ob(nb, 32'h0000_0008);
			rd(`QSM_A_STAT, {22'h00_0000, 2'h1, 7'h00, s != 1});
			if (s < 3) begin
				rd(`QSM_A_RXD, 32'h0000_00A5);
			end else begin
				wr(`QSM_A_EXEC, 32'h0000_0004);
				rd(`QSM_A_STAT, 32'h0000_0000);
			end
		end
		$display("sources done");
		for (int i = 0; i < 5; i++) begin
			start(cfg(16'h0001, i == 0, 2'h0, ts[i], tm[i]), 1'b0);
			wait_idle();
			ob(oe_or, to[i]);
		end
		$display("lanes done");
		for (int z = 1; z < 4; z++) begin
			nby = (z == 3) ? 4 : z;
			nacc = 0;
			ed = 32'h0000_0000;
			dma_on = 1'b1;
			start(cfg(16'h0004, 1'b0, z[1:0], 2'h1, 2'h0), 1'b0);
			wait_idle();
			dma_on = 1'b0;
			ob(32'(nacc), 32'(4 / nby));
			ob(seen, ed);
			ob(TX_DMA_REQ, 32'h0000_0000);
		end
		$display("dma done");
		// Length in bits with close-on-end cleared: select stays low.
		start(cfg(16'h000C, 1'b0, 2'h0, 2'h3, 2'h0) ^
			32'h0000_0600, 1'b0);
		wait_idle();
		ob(nb, 32'h0000_000C);
		ob(seen[11:0], 32'h0000_0FFF);
		ob(SPI_CS_N, 32'h0000_0000);
		wr(`QSM_A_EXEC, 32'h0000_0002);
		repeat (3) @(posedge CLK_SYS);
		ob(SPI_CS_N, 32'h0000_0001);
		$display("bit length done");
		start(cfg(16'h0000, 1'b0, 2'h1, 2'h3, 2'h0), 1'b0);
		repeat (300) @(posedge CLK_SYS);
		ob(TX_DMA_REQ, 32'h0000_0001);
		@(posedge CLK_SYS);
		DMA_TERM <= 1'b1;
		@(posedge CLK_SYS);
		DMA_TERM <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		ob(TX_DMA_REQ, 32'h0000_0000);
		rd(`QSM_A_STAT, 32'h0001_0000);
		wr(`QSM_A_EXEC, 32'h0000_0002);
		wait_idle();
		ob(TRANSFER_ACTIVE, 32'h0000_0000);
		ob(nb % 8, 32'h0000_0000);
		ob(seen, 32'hFFFF_FFFF);
		ob(SPI_CS_N, 32'h0000_0001);
		$display("halt done");
		repeat (4) @(posedge CLK_SYS);
		summarize();
	end
endmodule

`default_nettype wire
